//--- rtl/vpa_map.svh
`ifndef VPA_MAP_SVH
`define VPA_MAP_SVH

`define VPA_ADDR_W          12
`define VPA_OFF_BRIGHTNESS  12'h028
`define VPA_OFF_EVEN_CTRL   12'h02c
`define VPA_OFF_GAIN_LOW    12'h030
`define VPA_OFF_ODD_CTRL    12'h0ac
`define VPA_OFF_STATUS      12'h0b0

`define VPA_RST_BRIGHTNESS  8'h00
`define VPA_RST_CTRL        8'h20
`define VPA_RST_GAIN_LOW    8'hd8

`define VPA_CTL_TRAP_BYP    7
`define VPA_CTL_YC_INPUT    6
`define VPA_CTL_PREFLT_BYP  5
`define VPA_CTL_CHR_INV     4
`define VPA_CTL_RESERVED    3
`define VPA_CTL_LGAIN_TOP   2
`define VPA_CTL_UGAIN_TOP   1
`define VPA_CTL_VGAIN_TOP   0

`define VPA_STS_FIELD_ODD   0
`define VPA_STS_CHR_PHASE   1
`define VPA_STS_OUT_VALID   2
`define VPA_STS_IN_READY    3

`define VPA_GAIN_UNITY      17'h000d8
`define VPA_LUMA_MAX        8'hff
`define VPA_PROD_MAX        17'h000ff

`define VPA_RESP_OKAY       2'h0
`define VPA_RESP_SLVERR     2'h2

`endif

//--- rtl/vpa_pkg.sv
package vpa_pkg;

    typedef enum logic {
        VPA_WR_IDLE,
        VPA_WR_RESP
    } vpa_wr_state_t;

    typedef logic [7:0] vpa_byte_t;

    typedef logic [8:0] vpa_gain_t;

    typedef logic [8:0] vpa_beat_t;

endpackage

//--- rtl/vpa_skid_buf.sv
`timescale 1ns/1ps

module vpa_skid_buf (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    input  wire vpa_pkg::vpa_beat_t in_data_i,
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output vpa_pkg::vpa_beat_t     out_data_o
);

    logic               skid_valid_q;
    vpa_pkg::vpa_beat_t skid_data_q;
    logic               push;
    logic               pop;
    logic               head_free;

    assign push      = in_valid_i & in_ready_o;
    assign pop       = out_valid_o & out_ready_i;
    assign head_free = ~out_valid_o | pop;

    // Ready comes from a flop so no combinational path to the source
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_valid_o  <= 1'b0;
            out_data_o   <= 9'h000;
            skid_valid_q <= 1'b0;
            skid_data_q  <= 9'h000;
            in_ready_o   <= 1'b0;
        end else begin
            if (head_free) begin
                if (skid_valid_q) begin
                    out_valid_o <= 1'b1;
                    out_data_o  <= skid_data_q;
                end else begin
                    out_valid_o <= push;
                    out_data_o  <= push ? in_data_i : out_data_o;
                end
            end
            if (head_free && skid_valid_q) begin
                skid_valid_q <= push;
                skid_data_q  <= push ? in_data_i : skid_data_q;
            end else if (!head_free && push) begin
                skid_valid_q <= 1'b1;
                skid_data_q  <= in_data_i;
            end
            in_ready_o <= ~((skid_valid_q & ~head_free)
                            | (push & ~head_free)
                            | (skid_valid_q & push));
        end
    end

endmodule

//--- rtl/vpa_top.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "vpa_map.svh"

module vpa_top (
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [11:0] S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [11:0] S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    input  wire logic [7:0]  PIX_LUMA_I,
    input  wire logic        PIX_LINE_START_I,
    input  wire logic        PIX_FIELD_ODD_I,
    input  wire logic        PIX_VALID_I,
    output logic             PIX_READY_O,
    input  wire logic [9:0]  LINE_START_OFFSET_I,
    input  wire logic [7:0]  U_GAIN_LOW_BYTE_I,
    input  wire logic [7:0]  V_GAIN_LOW_BYTE_I,
    output logic [7:0]       OUT_LUMA_O,
    output logic             OUT_CHROMA_IS_CR_O,
    output logic             OUT_VALID_O,
    input  wire logic        OUT_READY_I,
    output logic             LUMA_TRAP_BYPASS_O,
    output logic             YC_INPUT_O,
    output logic             CHROMA_CONV_EN_O,
    output logic             LUMA_PREFILTER_BYPASS_O,
    output logic [8:0]       U_GAIN_O,
    output logic [8:0]       V_GAIN_O
);

    function automatic vpa_pkg::vpa_byte_t add_offset(
        input vpa_pkg::vpa_byte_t y,
        input vpa_pkg::vpa_byte_t off
    );
        logic signed [9:0] sum;
        sum = $signed({2'b00, y}) + $signed({{2{off[7]}}, off});
        if (sum < 0) begin
            add_offset = 8'h00;
        end else if (sum > $signed({2'b00, `VPA_LUMA_MAX})) begin
            add_offset = `VPA_LUMA_MAX;
        end else begin
            add_offset = sum[7:0];
        end
    endfunction

    function automatic vpa_pkg::vpa_byte_t apply_gain(
        input vpa_pkg::vpa_byte_t y,
        input vpa_pkg::vpa_gain_t g
    );
        logic [16:0] prod;
        logic [16:0] quot;
        prod = {9'h000, y} * {8'h00, g};
        quot = prod / `VPA_GAIN_UNITY;
        if (quot > `VPA_PROD_MAX) begin
            apply_gain = `VPA_LUMA_MAX;
        end else begin
            apply_gain = quot[7:0];
        end
    endfunction

    // Register storage
    vpa_pkg::vpa_byte_t    brightness_q;
    vpa_pkg::vpa_byte_t    even_ctrl_q;
    vpa_pkg::vpa_byte_t    odd_ctrl_q;
    vpa_pkg::vpa_byte_t    gain_low_q;

    // Write channel
    vpa_pkg::vpa_wr_state_t wr_state_q;
    vpa_pkg::vpa_wr_state_t wr_state_d;
    logic                   aw_have_q;
    logic                   aw_have_d;
    logic                   w_have_q;
    logic                   w_have_d;
    logic [11:0]            aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   aw_fire;
    logic                   w_fire;
    logic                   do_write;
    logic [11:0]            wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   wr_lane0;
    logic                   wr_hit_luma_offset;
    logic                   wr_hit_even;
    logic                   wr_hit_odd;
    logic                   wr_hit_gain;
    logic                   wr_hit_any;
    logic                   wr_mapped;
    logic                   b_done;

    // Read channel
    logic                   ar_fire;
    logic                   r_done;
    logic                   rd_mapped;
    vpa_pkg::vpa_byte_t     rd_byte;
    vpa_pkg::vpa_byte_t     status_byte;

    // Stream path
    logic                   in_ready;
    logic                   in_take;
    vpa_pkg::vpa_byte_t     ctl_sel;
    vpa_pkg::vpa_gain_t     luma_gain;
    vpa_pkg::vpa_byte_t     luma_luma_offset;
    vpa_pkg::vpa_byte_t     luma_final;
    logic                   phase_d;
    logic                   phase_q;
    logic                   field_odd_q;
    vpa_pkg::vpa_beat_t     beat_in;
    vpa_pkg::vpa_beat_t     beat_out;
    logic                   out_valid;

    assign aw_fire  = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_fire   = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign do_write = (wr_state_q == vpa_pkg::VPA_WR_IDLE)
                      & (aw_have_q | aw_fire) & (w_have_q | w_fire);
    assign wr_addr  = aw_have_q ? aw_addr_q : S_AXI_AWADDR_I;
    assign wr_data  = w_have_q ? w_data_q : S_AXI_WDATA_I;
    assign wr_strb  = w_have_q ? w_strb_q : S_AXI_WSTRB_I;
    assign wr_lane0 = do_write & wr_strb[0];
    assign b_done   = S_AXI_BVALID_O & S_AXI_BREADY_I;

    assign wr_hit_luma_offset = wr_addr == `VPA_OFF_BRIGHTNESS;
    assign wr_hit_even   = wr_addr == `VPA_OFF_EVEN_CTRL;
    assign wr_hit_odd    = wr_addr == `VPA_OFF_ODD_CTRL;
    assign wr_hit_gain   = wr_addr == `VPA_OFF_GAIN_LOW;
    assign wr_hit_any    = wr_hit_luma_offset | wr_hit_even
                           | wr_hit_odd | wr_hit_gain;
    // Status is read-only; a write there is refused
    assign wr_mapped     = wr_hit_any;

    assign aw_have_d = (aw_have_q | aw_fire) & ~do_write;
    assign w_have_d  = (w_have_q | w_fire) & ~do_write;

    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            vpa_pkg::VPA_WR_IDLE: begin
                if (do_write) begin
                    wr_state_d = vpa_pkg::VPA_WR_RESP;
                end
            end
            vpa_pkg::VPA_WR_RESP: begin
                if (b_done) begin
                    wr_state_d = vpa_pkg::VPA_WR_IDLE;
                end
            end
            default: begin
                wr_state_d = vpa_pkg::VPA_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            wr_state_q      <= vpa_pkg::VPA_WR_IDLE;
            aw_have_q       <= 1'b0;
            w_have_q        <= 1'b0;
            aw_addr_q       <= 12'h000;
            w_data_q        <= 32'h00000000;
            w_strb_q        <= 4'h0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= `VPA_RESP_OKAY;
        end else begin
            wr_state_q      <= wr_state_d;
            aw_have_q       <= aw_have_d;
            w_have_q        <= w_have_d;
            aw_addr_q       <= aw_fire ? S_AXI_AWADDR_I : aw_addr_q;
            w_data_q        <= w_fire ? S_AXI_WDATA_I : w_data_q;
            w_strb_q        <= w_fire ? S_AXI_WSTRB_I : w_strb_q;
            S_AXI_AWREADY_O <= (wr_state_d == vpa_pkg::VPA_WR_IDLE)
                               & ~aw_have_d;
            S_AXI_WREADY_O  <= (wr_state_d == vpa_pkg::VPA_WR_IDLE)
                               & ~w_have_d;
            S_AXI_BVALID_O  <= wr_state_d == vpa_pkg::VPA_WR_RESP;
            if (do_write) begin
                S_AXI_BRESP_O <= wr_mapped ? `VPA_RESP_OKAY
                                           : `VPA_RESP_SLVERR;
            end
        end
    end

    // Reserved bit 3 is stored as written; only software keeps it zero
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            brightness_q <= `VPA_RST_BRIGHTNESS;
            even_ctrl_q  <= `VPA_RST_CTRL;
            odd_ctrl_q   <= `VPA_RST_CTRL;
            gain_low_q   <= `VPA_RST_GAIN_LOW;
        end else if (wr_lane0) begin
            if (wr_hit_luma_offset) begin
                brightness_q <= wr_data[7:0];
            end
            if (wr_hit_even) begin
                even_ctrl_q <= wr_data[7:0];
            end
            if (wr_hit_odd) begin
                odd_ctrl_q <= wr_data[7:0];
            end
            if (wr_hit_gain) begin
                gain_low_q <= wr_data[7:0];
            end
        end
    end

    assign status_byte = {4'h0, in_ready, out_valid, phase_q, field_odd_q};
    assign ar_fire     = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign r_done      = S_AXI_RVALID_O & S_AXI_RREADY_I;
    assign rd_mapped   = (S_AXI_ARADDR_I == `VPA_OFF_BRIGHTNESS)
                         | (S_AXI_ARADDR_I == `VPA_OFF_EVEN_CTRL)
                         | (S_AXI_ARADDR_I == `VPA_OFF_ODD_CTRL)
                         | (S_AXI_ARADDR_I == `VPA_OFF_GAIN_LOW)
                         | (S_AXI_ARADDR_I == `VPA_OFF_STATUS);
    assign rd_byte =
        (S_AXI_ARADDR_I == `VPA_OFF_BRIGHTNESS) ? brightness_q :
        (S_AXI_ARADDR_I == `VPA_OFF_EVEN_CTRL)  ? even_ctrl_q  :
        (S_AXI_ARADDR_I == `VPA_OFF_ODD_CTRL)   ? odd_ctrl_q   :
        (S_AXI_ARADDR_I == `VPA_OFF_GAIN_LOW)   ? gain_low_q   :
        (S_AXI_ARADDR_I == `VPA_OFF_STATUS)     ? status_byte  : 8'h00;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h00000000;
            S_AXI_RRESP_O   <= `VPA_RESP_OKAY;
        end else if (ar_fire) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= {24'h000000, rd_byte};
            S_AXI_RRESP_O   <= rd_mapped ? `VPA_RESP_OKAY
                                         : `VPA_RESP_SLVERR;
        end else if (r_done) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
        end
    end

    // Field copy chosen by the sample's own field flag
    assign in_take   = PIX_VALID_I & in_ready;
    assign ctl_sel   = PIX_FIELD_ODD_I ? odd_ctrl_q : even_ctrl_q;
    assign luma_gain = {ctl_sel[`VPA_CTL_LGAIN_TOP], gain_low_q};
    // Offset first, then gain; both clamp instead of wrapping
    assign luma_luma_offset = add_offset(PIX_LUMA_I, brightness_q);
    assign luma_final  = apply_gain(luma_luma_offset, luma_gain);

    // Phase 1 means Cr; line start parity xor invert picks the first
    assign phase_d = PIX_LINE_START_I
                     ? (LINE_START_OFFSET_I[0]
                        ^ ctl_sel[`VPA_CTL_CHR_INV])
                     : ~phase_q;
    assign beat_in = {phase_d, luma_final};

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            phase_q     <= 1'b1;
            field_odd_q <= 1'b0;
        end else if (in_take) begin
            phase_q     <= phase_d;
            field_odd_q <= PIX_FIELD_ODD_I;
        end
    end

    // Front-end controls follow the field of the last accepted sample
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            LUMA_TRAP_BYPASS_O      <= 1'b0;
            YC_INPUT_O              <= 1'b0;
            CHROMA_CONV_EN_O        <= 1'b0;
            LUMA_PREFILTER_BYPASS_O <= 1'b1;
            U_GAIN_O                <= 9'h000;
            V_GAIN_O                <= 9'h000;
        end else begin
            LUMA_TRAP_BYPASS_O <= (field_odd_q ? odd_ctrl_q[7:6]
                                  : even_ctrl_q[7:6]) != 2'b00;
            YC_INPUT_O         <= field_odd_q
                                  ? odd_ctrl_q[`VPA_CTL_YC_INPUT]
                                  : even_ctrl_q[`VPA_CTL_YC_INPUT];
            CHROMA_CONV_EN_O   <= field_odd_q
                                  ? odd_ctrl_q[`VPA_CTL_YC_INPUT]
                                  : even_ctrl_q[`VPA_CTL_YC_INPUT];
            LUMA_PREFILTER_BYPASS_O <= field_odd_q
                                  ? odd_ctrl_q[`VPA_CTL_PREFLT_BYP]
                                  : even_ctrl_q[`VPA_CTL_PREFLT_BYP];
            U_GAIN_O <= {(field_odd_q ? odd_ctrl_q[`VPA_CTL_UGAIN_TOP]
                                      : even_ctrl_q[`VPA_CTL_UGAIN_TOP]),
                         U_GAIN_LOW_BYTE_I};
            V_GAIN_O <= {(field_odd_q ? odd_ctrl_q[`VPA_CTL_VGAIN_TOP]
                                      : even_ctrl_q[`VPA_CTL_VGAIN_TOP]),
                         V_GAIN_LOW_BYTE_I};
        end
    end

    // Two entries so a receiver stall loses no sample
    vpa_skid_buf u_buf (
        .clk_i       (REF_CLK_I),
        .rst_n_i     (RESET_N_I),
        .in_valid_i  (PIX_VALID_I),
        .in_ready_o  (in_ready),
        .in_data_i   (beat_in),
        .out_valid_o (out_valid),
        .out_ready_i (OUT_READY_I),
        .out_data_o  (beat_out)
    );

    assign PIX_READY_O        = in_ready;
    assign OUT_VALID_O        = out_valid;
    assign OUT_LUMA_O         = beat_out[7:0];
    assign OUT_CHROMA_IS_CR_O = beat_out[8];

endmodule

//--- testbench/vpa_top_assertions.sv
`timescale 1ns/1ps

module vpa_chk (
    input  wire logic       REF_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic       S_AXI_AWVALID_I,
    input  wire logic       S_AXI_AWREADY_O,
    input  wire logic       S_AXI_WVALID_I,
    input  wire logic       S_AXI_WREADY_O,
    input  wire logic       S_AXI_BVALID_O,
    input  wire logic       S_AXI_ARVALID_I,
    input  wire logic       S_AXI_ARREADY_O,
    input  wire logic       S_AXI_RVALID_O,
    input  wire logic [31:0] S_AXI_RDATA_O,
    input  wire logic       PIX_VALID_I,
    input  wire logic       PIX_READY_O,
    input  wire logic [7:0] OUT_LUMA_O,
    input  wire logic       OUT_CHROMA_IS_CR_O,
    input  wire logic       OUT_VALID_O,
    input  wire logic       OUT_READY_I,
    input  wire logic       LUMA_TRAP_BYPASS_O,
    input  wire logic       YC_INPUT_O,
    input  wire logic       CHROMA_CONV_EN_O,
    input  wire logic       LUMA_PREFILTER_BYPASS_O,
    input  wire logic [7:0] U_GAIN_LOW_BYTE_I,
    input  wire logic [8:0] U_GAIN_O
);
    default clocking dcb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    AST_YC_FORCES_TRAP: assert property (YC_INPUT_O |-> LUMA_TRAP_BYPASS_O)
        else $error("trap filter not bypassed in y/c mode");
    AST_CONV_FOLLOWS_YC: assert property (CHROMA_CONV_EN_O == YC_INPUT_O)
        else $error("chroma converter enable differs from input type");
    AST_U_LOW_BYTE: assert property ($past(RESET_N_I) |-> U_GAIN_O[7:0] == $past(U_GAIN_LOW_BYTE_I))
        else $error("u gain low byte not passed through");
    AST_RST_FIELD_OUTS: assert property (disable iff (1'b0) !RESET_N_I |=> LUMA_PREFILTER_BYPASS_O && !LUMA_TRAP_BYPASS_O && !YC_INPUT_O)
        else $error("field outputs wrong after reset");
    AST_RST_STREAM: assert property (disable iff (1'b0) !RESET_N_I |=> !OUT_VALID_O && !PIX_READY_O)
        else $error("stream not idle after reset");
    AST_OUT_HOLD: assert property (OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_LUMA_O) && $stable(OUT_CHROMA_IS_CR_O))
        else $error("output beat changed while stalled");
    AST_PIX_TO_OUT: assert property (PIX_VALID_I && PIX_READY_O && !OUT_VALID_O |=> OUT_VALID_O)
        else $error("accepted sample not presented next cycle");
    AST_RD_ANSWER: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read not answered one cycle after address");
    AST_RD_UPPER: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_WR_ANSWER: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |=> S_AXI_BVALID_O ##0 !S_AXI_AWREADY_O)
        else $error("write not answered one cycle after address and data");
endmodule

bind vpa_top vpa_chk vpa_chk_i (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .PIX_VALID_I(PIX_VALID_I),
    .PIX_READY_O(PIX_READY_O), .OUT_LUMA_O(OUT_LUMA_O),
    .OUT_CHROMA_IS_CR_O(OUT_CHROMA_IS_CR_O), .OUT_VALID_O(OUT_VALID_O),
    .OUT_READY_I(OUT_READY_I), .LUMA_TRAP_BYPASS_O(LUMA_TRAP_BYPASS_O),
    .YC_INPUT_O(YC_INPUT_O), .CHROMA_CONV_EN_O(CHROMA_CONV_EN_O),
    .LUMA_PREFILTER_BYPASS_O(LUMA_PREFILTER_BYPASS_O),
    .U_GAIN_LOW_BYTE_I(U_GAIN_LOW_BYTE_I), .U_GAIN_O(U_GAIN_O)
);

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "vpa_map.svh"

module tb;
    logic        REF_CLK_I = 1'b0, RESET_N_I = 1'b0;
    logic [11:0] S_AXI_AWADDR_I = 12'h000, S_AXI_ARADDR_I = 12'h000;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
    logic [3:0]  S_AXI_WSTRB_I = 4'h0;
    logic        S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
    logic        S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
    logic        S_AXI_RREADY_I = 1'b0, OUT_READY_I = 1'b1;
    logic        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
    logic        S_AXI_ARREADY_O, S_AXI_RVALID_O, PIX_READY_O;
    logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic [7:0]  PIX_LUMA_I = 8'h00, OUT_LUMA_O;
    logic        PIX_LINE_START_I = 1'b0, PIX_FIELD_ODD_I = 1'b0;
    logic        PIX_VALID_I = 1'b0;
    logic [9:0]  LINE_START_OFFSET_I = 10'h000;
    logic [7:0]  U_GAIN_LOW_BYTE_I = 8'h5a, V_GAIN_LOW_BYTE_I = 8'ha5;
    logic        OUT_CHROMA_IS_CR_O, OUT_VALID_O, LUMA_TRAP_BYPASS_O;
    logic        YC_INPUT_O, CHROMA_CONV_EN_O, LUMA_PREFILTER_BYPASS_O;
    logic [8:0]  U_GAIN_O, V_GAIN_O;
    int          n_errors = 0, comparisons = 0;
    logic [8:0]  got_q[$];
    logic [7:0]  cl[7] = '{8'h10, 8'hf0, 8'h40, 8'h40, 8'h40, 8'h64, 8'hff};
    logic [7:0]  cb[7] = '{8'h80, 8'h7f, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [8:0]  cg[7] = '{9'h0d8, 9'h0d8, 9'h0d8, 9'h0d8, 9'h000, 9'h1ff,
                           9'h1ff};

    vpa_top vpa_top_i (
        .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
        .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
        .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
        .S_AXI_WSTRB_I(S_AXI_WSTRB_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
        .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
        .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
        .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
        .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
        .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
        .S_AXI_RREADY_I(S_AXI_RREADY_I), .PIX_LUMA_I(PIX_LUMA_I),
        .PIX_LINE_START_I(PIX_LINE_START_I), .PIX_FIELD_ODD_I(PIX_FIELD_ODD_I),
        .PIX_VALID_I(PIX_VALID_I), .PIX_READY_O(PIX_READY_O),
        .LINE_START_OFFSET_I(LINE_START_OFFSET_I),
        .U_GAIN_LOW_BYTE_I(U_GAIN_LOW_BYTE_I),
        .V_GAIN_LOW_BYTE_I(V_GAIN_LOW_BYTE_I), .OUT_LUMA_O(OUT_LUMA_O),
        .OUT_CHROMA_IS_CR_O(OUT_CHROMA_IS_CR_O), .OUT_VALID_O(OUT_VALID_O),
        .OUT_READY_I(OUT_READY_I), .LUMA_TRAP_BYPASS_O(LUMA_TRAP_BYPASS_O),
        .YC_INPUT_O(YC_INPUT_O), .CHROMA_CONV_EN_O(CHROMA_CONV_EN_O),
        .LUMA_PREFILTER_BYPASS_O(LUMA_PREFILTER_BYPASS_O),
        .U_GAIN_O(U_GAIN_O), .V_GAIN_O(V_GAIN_O)
    );

    always #2.5 REF_CLK_I = ~REF_CLK_I;

    // Every delivered beat is queued, so stalls cannot hide a lost word
    always @(posedge REF_CLK_I) begin
        if (OUT_VALID_O === 1'b1 && OUT_READY_I === 1'b1)
            got_q.push_back({OUT_CHROMA_IS_CR_O, OUT_LUMA_O});
    end

    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic axw(logic [11:0] a, logic [7:0] d, logic [3:0] s,
                       logic [1:0] r);
        int n;
        n = 0;
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= {24'h000000, d};
        S_AXI_WSTRB_I <= s;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        do begin
            @(posedge REF_CLK_I);
            n++;
            if (S_AXI_AWREADY_O === 1'b1) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O === 1'b1) S_AXI_WVALID_I <= 1'b0;
        end while (S_AXI_BVALID_O !== 1'b1 && n < 50);
        chk("bresp", {29'h0, 1'b1, r},
            {29'h0, S_AXI_BVALID_O, S_AXI_BRESP_O});
    endtask

    task automatic axr(logic [11:0] a, logic [7:0] d, logic [1:0] r);
        int n;
        n = 0;
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do begin
            @(posedge REF_CLK_I);
            n++;
            if (S_AXI_ARREADY_O === 1'b1) S_AXI_ARVALID_I <= 1'b0;
        end while (S_AXI_RVALID_O !== 1'b1 && n < 50);
        chk("rdata", {24'h000000, d}, S_AXI_RDATA_O);
        chk("rresp", {29'h0, 1'b1, r},
            {29'h0, S_AXI_RVALID_O, S_AXI_RRESP_O});
    endtask

    // Leaves valid high so samples can follow back to back
    task automatic pix(logic [7:0] l, logic ls, logic odd);
        int n;
        n = 0;
        PIX_LUMA_I <= l;
        PIX_LINE_START_I <= ls;
        PIX_FIELD_ODD_I <= odd;
        PIX_VALID_I <= 1'b1;
        do begin
            @(posedge REF_CLK_I);
            n++;
        end while (PIX_READY_O !== 1'b1 && n < 100);
    endtask

    task automatic get(logic [7:0] l, logic cr);
        int n;
        for (n = 0; n < 100 && got_q.size() == 0; n++) @(posedge REF_CLK_I);
        if (got_q.size() == 0) chk("beat present", 32'h1, 32'h0);
        else chk("beat", {23'h0, cr, l}, {23'h0, got_q.pop_front()});
    endtask

    function automatic logic [7:0] adj(logic [7:0] l, logic [7:0] b,
                                       logic [8:0] g);
        int y;
        y = int'(l) + int'($signed(b));
        y = (y < 0) ? 0 : (y > 255) ? 255 : y;
        y = y * int'(g) / 216;
        return (y > 255) ? 8'hff : y[7:0];
    endfunction

    task automatic fld(logic tr, logic yc, logic pf, logic top);
        repeat (2) @(posedge REF_CLK_I);
        chk("field outs", {tr, yc, yc, pf}, {LUMA_TRAP_BYPASS_O, YC_INPUT_O,
            CHROMA_CONV_EN_O, LUMA_PREFILTER_BYPASS_O});
        chk("gains", {top, U_GAIN_LOW_BYTE_I, top, V_GAIN_LOW_BYTE_I},
            {U_GAIN_O, V_GAIN_O});
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK_I);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge REF_CLK_I);
        RESET_N_I <= 1'b1;
        @(posedge REF_CLK_I);
        axr(`VPA_OFF_BRIGHTNESS, 8'h00, 2'h0);
        axr(`VPA_OFF_EVEN_CTRL, 8'h20, 2'h0);
        axr(`VPA_OFF_ODD_CTRL, 8'h20, 2'h0);
        axr(`VPA_OFF_GAIN_LOW, 8'hd8, 2'h0);
        axr(12'h100, 8'h00, 2'h2);
        axw(12'h100, 8'h11, 4'hf, 2'h2);
        axw(`VPA_OFF_STATUS, 8'h11, 4'hf, 2'h2);
        axw(`VPA_OFF_ODD_CTRL, 8'h52, 4'h0, 2'h0);
        axr(`VPA_OFF_ODD_CTRL, 8'h20, 2'h0);
        axw(`VPA_OFF_BRIGHTNESS, 8'h7f, 4'hf, 2'h0);
        axr(`VPA_OFF_BRIGHTNESS, 8'h7f, 2'h0);
        // Signed offset, clamps and gain over 216
        for (int i = 0; i < 7; i++) begin
            axw(`VPA_OFF_BRIGHTNESS, cb[i], 4'hf, 2'h0);
            axw(`VPA_OFF_GAIN_LOW, cg[i][7:0], 4'hf, 2'h0);
            axw(`VPA_OFF_EVEN_CTRL, {5'h04, cg[i][8], 2'h0}, 4'hf, 2'h0);
            pix(cl[i], 1'b1, 1'b0);
            PIX_VALID_I <= 1'b0;
            get(adj(cl[i], cb[i], cg[i]), 1'b0);
        end
        // Odd copy differs in bits 7:5 and 2:0 so a swapped copy shows
        axw(`VPA_OFF_BRIGHTNESS, 8'h00, 4'hf, 2'h0);
        axw(`VPA_OFF_GAIN_LOW, 8'h00, 4'hf, 2'h0);
        axw(`VPA_OFF_EVEN_CTRL, 8'ha0, 4'hf, 2'h0);
        axw(`VPA_OFF_ODD_CTRL, 8'h47, 4'hf, 2'h0);
        pix(8'h40, 1'b1, 1'b0);
        PIX_VALID_I <= 1'b0;
        get(8'h00, 1'b0);
        fld(1'b1, 1'b0, 1'b1, 1'b0);
        pix(8'h40, 1'b1, 1'b1);
        PIX_VALID_I <= 1'b0;
        get(adj(8'h40, 8'h00, 9'h100), 1'b0);
        U_GAIN_LOW_BYTE_I <= 8'h3c;
        V_GAIN_LOW_BYTE_I <= 8'hc3;
        fld(1'b1, 1'b1, 1'b0, 1'b1);
        axw(`VPA_OFF_GAIN_LOW, 8'hd8, 4'hf, 2'h0);
        // Every parity and order-bit pair
        for (int k = 0; k < 4; k++) begin
            LINE_START_OFFSET_I <= {9'h001, k[0]};
            axw(`VPA_OFF_EVEN_CTRL, {3'h1, k[1], 4'h0}, 4'hf, 2'h0);
            pix(8'h20, 1'b1, 1'b0);
            pix(8'h21, 1'b0, 1'b0);
            pix(8'h22, 1'b0, 1'b0);
            PIX_VALID_I <= 1'b0;
            get(8'h20, k[0] ^ k[1]);
            get(8'h21, ~(k[0] ^ k[1]));
            get(8'h22, k[0] ^ k[1]);
        end
        // Receiver stalls while three samples are offered
        OUT_READY_I <= 1'b0;
        fork
            begin
                pix(8'h30, 1'b1, 1'b0);
                pix(8'h31, 1'b0, 1'b0);
                pix(8'h32, 1'b0, 1'b0);
                PIX_VALID_I <= 1'b0;
            end
        join_none
        repeat (12) @(posedge REF_CLK_I);
        chk("beats during stall", 32'h0, got_q.size());
        OUT_READY_I <= 1'b1;
        get(8'h30, 1'b0);
        get(8'h31, 1'b1);
        get(8'h32, 1'b0);
        axr(`VPA_OFF_STATUS, 8'h08, 2'h0);
        complete_run();
    end
endmodule
